// ===== bench/host_line_model.sv
// Host partner on the shared serial line: sends characters, decodes replies.
// Assumes the bench feeds line back to the device input; pull-up is here.
`timescale 1ns/100ps
`default_nettype none
module host_line_model #(
  parameter int BIT_CYCLES = 16
) (
  // Clock and line
  input  wire logic pclk,
  input  wire logic dev_oe,
  output logic      line,
  // Decoded byte
  output logic       got,
  output logic [7:0] got_byte
);
  logic host_oe = 1'b0;
  // =========================
  // Wired line
  // Pull-up wins unless a party drives low
  assign line = !(dev_oe || host_oe);
  // =========================
  // Sender
  // Whole frame in one go, never interrupted
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_oe <= !f[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    host_oe <= 1'b0;
  endtask
  // =========================
  // Receiver, mid-bit sampling
  initial begin
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(posedge pclk);
      got <= 1'b0;
      if (dev_oe) begin
        repeat (BIT_CYCLES / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge pclk);
          got_byte[i] <= line;
        end
        repeat (BIT_CYCLES) @(posedge pclk);
        got <= line;
      end
    end
  end
endmodule // host_line_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the range checker and its serial byte link.
// Assumes host_line_model on the line and a 256-byte memory image.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rd_en, line, l_out, l_oe, wdog, irq, got;
  logic [15:0] mem_addr;
  logic [7:0]  mem [256];
  logic [7:0]  mem_rd_data, got_byte, sum, bv;
  logic [7:0]  v [4];
  logic [64:0] rq [$];
  logic [7:0]  lq [$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          wd_n = 0;
  assign mem_rd_data = mem[mem_addr[7:0]];
  serial_byte_link_range_check #(.BIT_CYCLES(16), .WDOG_PERIOD(32))
    i_serial_byte_link_range_check (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd_en(rd_en),
    .mem_rd_data(mem_rd_data), .serial_line_in(line), .serial_line_out(l_out),
    .serial_line_oe(l_oe), .watchdog_service(wdog), .irq(irq));
  host_line_model #(.BIT_CYCLES(16)) i_host_line_model (.pclk(pclk), .dev_oe(l_oe),
    .line(line), .got(got), .got_byte(got_byte));
  initial forever #25 pclk = ~pclk;
  // =========================
  // Checking
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (wdog) wd_n++;
    if (l_oe) cmp(32'(l_out), 0);
    if (got) cmp(32'(got_byte), 32'(lq.pop_front()));
    if (psel && penable && pready && !pwrite) begin
      cmp(prdata & rq[0][63:32], rq[0][31:0] & rq[0][63:32]);
      cmp(32'(pslverr), 32'(rq.pop_front() >> 64));
    end
  end
  // =========================
  // APB master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({1'b0, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      test_done();
    end
  endtask
  // =========================
  // Scenarios
  initial begin
    void'($urandom(46539));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(slink_pkg::OFF_INDEX, 32'h0, 32'hFFFFFFFF);
    rd(slink_pkg::OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF);
    rq.push_back({1'b1, 64'h0});
    apb(1'b0, 8'hFC, 32'h0);
    wr(slink_pkg::OFF_IRQ_MASK, 32'hF);
    // Good character, then one with a low stop bit
    for (int k = 0; k < 2; k++) begin
      bv = 8'($urandom);
      wd_n = 0;
      wr(slink_pkg::OFF_CTRL, 32'h2);
      repeat (300) @(posedge pclk);
      cmp(32'(irq), 0);
      i_host_line_model.send(bv, k == 0);
      wait_irq();
      rd(slink_pkg::OFF_RXDATA, 32'(bv), (k == 0) ? 32'hFF : 32'h0);
      rd(slink_pkg::OFF_STATUS, 32'(k == 0), 32'h1);
      rd(slink_pkg::OFF_IRQ_STAT, (k == 0) ? 32'h1 : 32'h8, (k == 0) ? 32'hF : 32'h8);
      wr(slink_pkg::OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      cmp(32'(irq), 0);
      wr(slink_pkg::OFF_IRQ_MASK, 32'hF);
      repeat (2) @(posedge pclk);
      cmp(32'(irq), 1);
      wr(slink_pkg::OFF_IRQ_STAT, 32'hF);
      rd(slink_pkg::OFF_IRQ_STAT, 32'h0, 32'hF);
      cmp(32'(wd_n), 0);
    end
    bv = 8'($urandom);
    lq.push_back(bv);
    wr(slink_pkg::OFF_TXDATA, 32'(bv));
    wr(slink_pkg::OFF_CTRL, 32'h4);
    wait_irq();
    rd(slink_pkg::OFF_IRQ_STAT, 32'h2, 32'hF);
    wr(slink_pkg::OFF_IRQ_STAT, 32'hF);
    cmp(32'(wd_n), 0);
    // Compare match, compare miss, send-out; range crosses a page
    for (int k = 0; k < 3; k++) begin
      sum = 8'h00;
      wd_n = 0;
      wr(slink_pkg::OFF_BUF_BASE, 32'h40);
      for (int i = 0; i < 4; i++) begin
        v[i] = 8'($urandom);
        mem[8'(i - 2)] = v[i];
        sum += v[i];
        if (k == 2) lq.push_back(v[i]);
        wr(slink_pkg::OFF_BUF_INDEX, 32'(64 + i));
        wr(slink_pkg::OFF_BUF_DATA, {24'h0, (k != 0 && i == 2) ? ~v[i] : v[i]});
      end
      wr(slink_pkg::OFF_OPTION, (k == 2) ? 32'h0 : 32'($urandom_range(255, 1)));
      wr(slink_pkg::OFF_INDEX, 32'h30FE);
      wr(slink_pkg::OFF_LAST, 32'h3101);
      wr(slink_pkg::OFF_IRQ_MASK, 32'h4);
      wr(slink_pkg::OFF_CTRL, 32'h1);
      wait_irq();
      rd(slink_pkg::OFF_STATUS, {16'h0, sum, 7'h0, k == 0}, (k == 2) ? 32'hFF00 : 32'hFF01);
      rd(slink_pkg::OFF_INDEX, 32'h3102, 32'hFFFF);
      for (int i = 0; i < 4; i++) begin
        wr(slink_pkg::OFF_BUF_INDEX, 32'(64 + i));
        rd(slink_pkg::OFF_BUF_DATA, {24'h0, (k == 2 && i == 2) ? ~v[i] : v[i]}, 32'hFF);
      end
      cmp(32'(wd_n > 0), 32'(k == 2));
      wr(slink_pkg::OFF_IRQ_STAT, 32'hF);
      wr(slink_pkg::OFF_IRQ_MASK, 32'hF);
    end
    cmp(32'(lq.size()), 0);
    test_done();
  end
endmodule // testbench
`default_nettype wire

// ===== design/serial_byte_link.sv
// Half-duplex NRZ byte receiver and transmitter on one pulled-up line.
// Assumes line_in is synchronous to pclk and the pin drives low only.
`default_nettype none
`timescale 1ns/100ps
module serial_byte_link #(
  parameter int BIT_CYCLES = slink_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests
  input  wire logic       rx_req,
  input  wire logic       tx_req,
  input  wire logic [7:0] tx_byte,
  // Line
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe,
  // Results
  output logic [7:0]      rx_byte,
  output logic            rx_ok,
  output logic            rx_done,
  output logic            tx_done,
  output logic            busy
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] RELOAD = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF   = CW'(BIT_CYCLES / 2 - 1);

  slink_pkg::link_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0]    bit_q, bit_d;
  logic [9:0]    sh_q, sh_d;
  logic [7:0]    rxb_q, rxb_d;
  logic          ok_q, ok_d, rxd_q, rxd_d, txd_q, txd_d, oe_q, oe_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    rxb_d = rxb_q;
    ok_d  = ok_q;
    rxd_d = 1'b0;
    txd_d = 1'b0;
    oe_d  = 1'b0;
    unique case (st_q)
      slink_pkg::L_IDLE: begin
        if (tx_req) begin
          // Start bit, data LSB first, stop bit
          sh_d  = {1'b1, tx_byte, 1'b0};
          cnt_d = RELOAD;
          bit_d = 4'h0;
          oe_d  = 1'b1;
          st_d  = slink_pkg::L_TX_BITS;
        end else if (rx_req) begin
          st_d = slink_pkg::L_RX_WAIT;
        end
      end
      slink_pkg::L_RX_WAIT: begin
        // No timeout: waits for a start bit as long as it takes
        if (!line_in) begin
          cnt_d = HALF;
          bit_d = 4'h0;
          st_d  = slink_pkg::L_RX_BITS;
        end
      end
      slink_pkg::L_RX_BITS: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          cnt_d = RELOAD;
          bit_d = bit_q + 1'b1;
          if (bit_q == 4'h0) begin
            // Glitch shorter than half a bit is no start
            if (line_in) st_d = slink_pkg::L_RX_WAIT;
          end else if (bit_q != 4'h9) begin
            sh_d = {sh_q[9:8], line_in, sh_q[7:1]};
          end else begin
            rxb_d = sh_q[7:0];
            ok_d  = line_in;
            rxd_d = 1'b1;
            st_d  = slink_pkg::L_IDLE;
          end
        end
      end
      slink_pkg::L_TX_BITS: begin
        oe_d = ~sh_q[0];
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          cnt_d = RELOAD;
          bit_d = bit_q + 1'b1;
          sh_d  = {1'b1, sh_q[9:1]};
          oe_d  = ~sh_d[0];
          if (bit_q == 4'h9) begin
            oe_d  = 1'b0;
            txd_d = 1'b1;
            st_d  = slink_pkg::L_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= slink_pkg::L_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q  <= 10'h3FF;
      rxb_q <= 8'h00;
      ok_q  <= 1'b0;
      rxd_q <= 1'b0;
      txd_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      rxb_q <= rxb_d;
      ok_q  <= ok_d;
      rxd_q <= rxd_d;
      txd_q <= txd_d;
      oe_q  <= oe_d;
    end
  end

  // Data value is fixed low; only the enable moves
  assign line_out = 1'b0;
  assign line_oe  = oe_q;
  assign rx_byte  = rxb_q;
  assign rx_ok    = ok_q;
  assign rx_done  = rxd_q;
  assign tx_done  = txd_q;
  assign busy     = (st_q != slink_pkg::L_IDLE);

  // ==========================================================
  // Checks
  a_stop_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done |-> rx_ok == $past(line_in))
    else $error("receive flag does not follow stop bit");
  a_bit_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == slink_pkg::L_TX_BITS && $past(st_q) == slink_pkg::L_TX_BITS
     && $changed(oe_q)) |-> $past(cnt_q) == '0)
    else $error("line changed inside a bit period");
  a_rx_waits_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == slink_pkg::L_RX_WAIT && line_in) |=> st_q == slink_pkg::L_RX_WAIT)
    else $error("receiver left wait without start bit");
  a_tx_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == slink_pkg::L_IDLE && tx_req) |=> oe_q [*8])
    else $error("start bit not driven low");
endmodule // serial_byte_link
`default_nettype wire

// ===== design/serial_byte_link_range_check.sv
// Range checker with APB registers, comparison buffer and serial link.
// Assumes memory read data is valid in the same pclk that mem_rd_en is high, and a
// pull-up on the serial line outside.
//
// Behaviour
// - Receiver takes one NRZ character from the line and returns its byte.
// - Result flag cleared on a missing stop bit, set otherwise.
// - One bit lasts 256 bus cycles for receive and transmit.
// - Receive waits forever for a low start bit, ends at the middle of the stop bit.
// - Line is pulled up, idles as input, only ever driven low.
// - Transmitter sends a byte on the same line with same framing.
// - Byte receive or send neither services watchdog nor masks interrupts.
// - Option byte zero selects send-out, any other value compare.
// - Send-out transmits every byte read, in order, over the line.
// - Compare checks each byte with buffer entry, then overwrites entry.
// - Range runs inclusively from index pair to last address.
// - Compare flag set only if all bytes match; meaningless in send-out.
// - Checksum is low byte of sum of all bytes read.
// - Range check services watchdog first at 24 cycles, interrupts unmasked.
// - Send-out leaves the buffer unread and unchanged.
// - Buffer lies in a 256-byte page; range may cross pages.
// - Index pair ends one past the last byte checked.
`default_nettype none
`timescale 1ns/100ps
module serial_byte_link_range_check #(
  parameter int BIT_CYCLES  = slink_pkg::BIT_CYCLES,
  parameter int WDOG_PERIOD = slink_pkg::WDOG_PERIOD
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Nonvolatile memory read port
  output logic [15:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rd_data,
  // Serial line pin
  input  wire logic        serial_line_in,
  output logic             serial_line_out,
  output logic             serial_line_oe,
  // System
  output logic             watchdog_service,
  output logic             irq
);
  localparam int WCW = $clog2(WDOG_PERIOD + 1);
  localparam logic [WCW-1:0] WD_FIRST  = WCW'(slink_pkg::WDOG_FIRST - 1);
  localparam logic [WCW-1:0] WD_RELOAD = WCW'(WDOG_PERIOD - 1);

  // ==========================================================
  // Link
  logic       link_rx_req, link_tx_req, link_busy;
  logic [7:0] link_tx_byte, link_rx_byte;
  logic       link_rx_ok, link_rx_done, link_tx_done;

  serial_byte_link #(.BIT_CYCLES(BIT_CYCLES)) u_link (
    .pclk    (pclk),
    .presetn (presetn),
    .rx_req  (link_rx_req),
    .tx_req  (link_tx_req),
    .tx_byte (link_tx_byte),
    .line_in (serial_line_in),
    .line_out(serial_line_out),
    .line_oe (serial_line_oe),
    .rx_byte (link_rx_byte),
    .rx_ok   (link_rx_ok),
    .rx_done (link_rx_done),
    .tx_done (link_tx_done),
    .busy    (link_busy)
  );

  // ==========================================================
  // APB decode
  logic apb_acc, apb_wr, apb_rd;
  assign apb_acc = psel & penable & pready;
  assign apb_wr  = apb_acc & pwrite;
  assign apb_rd  = psel & penable & ~pready & ~pwrite;

  logic [7:0]  option_q, option_d, txdata_q, txdata_d, rxdata_q, rxdata_d;
  logic [15:0] index_q, index_d, last_q, last_d;
  logic [7:0]  buf_base_q, buf_base_d, buf_index_q, buf_index_d;
  logic [7:0]  bptr_q, bptr_d, sum_q, sum_d;
  logic        flag_q, flag_d;
  logic [slink_pkg::NUM_EVENTS-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic        ready_q, ready_d, err_q, err_d, irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] maddr_q, maddr_d;
  logic        mrd_q, mrd_d, wd_q, wd_d;
  logic [WCW-1:0] wdc_q, wdc_d;
  slink_pkg::verify_state_t vs_q, vs_d;

  // Comparison buffer: one 256-byte page, index wraps inside it
  logic [7:0] buf_mem [slink_pkg::BUF_DEPTH];
  logic       buf_we;
  logic [7:0] buf_waddr, buf_wdata, buf_rd;

  logic ctrl_wr, go_verify, go_rx, go_tx, v_busy, mismatch;
  assign ctrl_wr   = apb_wr && paddr == slink_pkg::OFF_CTRL;
  assign v_busy    = (vs_q != slink_pkg::V_IDLE);
  // Refused while anything else runs: the line is shared
  assign go_verify = ctrl_wr && pwdata[slink_pkg::CTRL_VERIFY] && !v_busy && !link_busy;
  assign go_rx     = ctrl_wr && pwdata[slink_pkg::CTRL_RX] && !v_busy && !link_busy;
  assign go_tx     = ctrl_wr && pwdata[slink_pkg::CTRL_TX] && !v_busy && !link_busy;
  assign buf_rd    = buf_mem[bptr_q];
  assign mismatch  = (vs_q == slink_pkg::V_DATA) && (option_q != slink_pkg::OPTION_SENDOUT)
                     && (buf_rd != mem_rd_data);

  // ==========================================================
  // Link request steering
  always_comb begin
    link_rx_req  = go_rx;
    link_tx_req  = go_tx;
    link_tx_byte = txdata_q;
    if (vs_q == slink_pkg::V_DATA && option_q == slink_pkg::OPTION_SENDOUT) begin
      link_tx_req  = 1'b1;
      link_tx_byte = mem_rd_data;
    end
  end

  // ==========================================================
  // Range checker
  always_comb begin
    vs_d      = vs_q;
    index_d   = index_q;
    bptr_d    = bptr_q;
    sum_d     = sum_q;
    flag_d    = flag_q;
    maddr_d   = maddr_q;
    mrd_d     = 1'b0;
    buf_we    = 1'b0;
    buf_waddr = bptr_q;
    buf_wdata = mem_rd_data;
    unique case (vs_q)
      slink_pkg::V_IDLE: begin
        if (go_verify) begin
          bptr_d = buf_base_q;
          sum_d  = 8'h00;
          flag_d = 1'b1;
          vs_d   = slink_pkg::V_READ;
        end else if (link_rx_done) begin
          flag_d = link_rx_ok;
        end
      end
      slink_pkg::V_READ: begin
        maddr_d = index_q;
        mrd_d   = 1'b1;
        vs_d    = slink_pkg::V_DATA;
      end
      slink_pkg::V_DATA: begin
        sum_d = sum_q + mem_rd_data;
        if (option_q == slink_pkg::OPTION_SENDOUT) begin
          // Buffer untouched in this mode
          vs_d = slink_pkg::V_SEND;
        end else begin
          if (mismatch) flag_d = 1'b0;
          buf_we = 1'b1;
          bptr_d = bptr_q + 8'h01;
          vs_d   = slink_pkg::V_NEXT;
        end
      end
      slink_pkg::V_SEND: begin
        if (link_tx_done) vs_d = slink_pkg::V_NEXT;
      end
      slink_pkg::V_NEXT: begin
        // Range may wrap past pages and rows freely
        index_d = index_q + 16'h0001;
        vs_d    = (index_q == last_q) ? slink_pkg::V_IDLE : slink_pkg::V_READ;
      end
      default: vs_d = slink_pkg::V_IDLE;
    endcase
    if (!v_busy && apb_wr && paddr == slink_pkg::OFF_INDEX) index_d = pwdata[15:0];
    if (!v_busy && apb_wr && paddr == slink_pkg::OFF_BUF_DATA) begin
      buf_we    = 1'b1;
      buf_waddr = buf_index_q;
      buf_wdata = pwdata[7:0];
    end
  end

  // Watchdog runs only with the range checker, never for lone bytes
  always_comb begin
    wdc_d = wdc_q;
    wd_d  = 1'b0;
    if (go_verify) begin
      wdc_d = WD_FIRST;
    end else if (v_busy) begin
      if (wdc_q == '0) begin
        wd_d  = 1'b1;
        wdc_d = WD_RELOAD;
      end else begin
        wdc_d = wdc_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers, events and read data
  assign ev[slink_pkg::EV_RX_DONE]   = link_rx_done;
  assign ev[slink_pkg::EV_TX_DONE]   = link_tx_done;
  assign ev[slink_pkg::EV_VERIFY]    = (vs_q == slink_pkg::V_NEXT) && (index_q == last_q);
  assign ev[slink_pkg::EV_FRAME_ERR] = link_rx_done && !link_rx_ok;

  always_comb begin
    option_d    = option_q;
    last_d      = last_q;
    txdata_d    = txdata_q;
    rxdata_d    = link_rx_done ? link_rx_byte : rxdata_q;
    buf_base_d  = buf_base_q;
    buf_index_d = buf_index_q;
    mask_d      = mask_q;
    stat_d      = stat_q;
    ready_d     = psel & penable & ~pready;
    err_d       = 1'b0;
    rdata_d     = rdata_q;
    if (apb_wr && !v_busy) begin
      unique case (paddr)
        slink_pkg::OFF_OPTION:    option_d    = pwdata[7:0];
        slink_pkg::OFF_LAST:      last_d      = pwdata[15:0];
        slink_pkg::OFF_TXDATA:    txdata_d    = pwdata[7:0];
        slink_pkg::OFF_BUF_BASE:  buf_base_d  = pwdata[7:0];
        slink_pkg::OFF_BUF_INDEX: buf_index_d = pwdata[7:0];
        default: ;
      endcase
    end
    if (apb_wr && paddr == slink_pkg::OFF_IRQ_MASK) mask_d = pwdata[slink_pkg::NUM_EVENTS-1:0];
    if (apb_wr && paddr == slink_pkg::OFF_IRQ_STAT) begin
      stat_d = stat_q & ~pwdata[slink_pkg::NUM_EVENTS-1:0];
    end
    // A new event outranks a clear in the same cycle
    stat_d = stat_d | ev;
    // Reads only: an unmapped write is ignored without an error
    if (apb_rd) begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        slink_pkg::OFF_CTRL:      ;
        slink_pkg::OFF_OPTION:    rdata_d[7:0]  = option_q;
        slink_pkg::OFF_INDEX:     rdata_d[15:0] = index_q;
        slink_pkg::OFF_LAST:      rdata_d[15:0] = last_q;
        slink_pkg::OFF_TXDATA:    rdata_d[7:0]  = txdata_q;
        slink_pkg::OFF_RXDATA:    rdata_d[7:0]  = rxdata_q;
        slink_pkg::OFF_STATUS: begin
          rdata_d[slink_pkg::ST_FLAG] = flag_q;
          rdata_d[slink_pkg::ST_BUSY] = v_busy | link_busy;
          rdata_d[slink_pkg::ST_SUM_LSB +: 8] = sum_q;
        end
        slink_pkg::OFF_IRQ_STAT:  rdata_d[slink_pkg::NUM_EVENTS-1:0] = stat_q;
        slink_pkg::OFF_IRQ_MASK:  rdata_d[slink_pkg::NUM_EVENTS-1:0] = mask_q;
        slink_pkg::OFF_BUF_BASE:  rdata_d[7:0]  = buf_base_q;
        slink_pkg::OFF_BUF_INDEX: rdata_d[7:0]  = buf_index_q;
        slink_pkg::OFF_BUF_DATA:  rdata_d[7:0]  = buf_mem[buf_index_q];
        default:                  err_d = 1'b1;
      endcase
    end
    // Interrupt is never gated by a running operation
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_q        <= slink_pkg::V_IDLE;
      option_q    <= slink_pkg::OPTION_SENDOUT;
      index_q     <= slink_pkg::ADDR_RESET;
      last_q      <= slink_pkg::ADDR_RESET;
      txdata_q    <= 8'h00;
      rxdata_q    <= 8'h00;
      buf_base_q  <= 8'h00;
      buf_index_q <= 8'h00;
      bptr_q      <= 8'h00;
      sum_q       <= 8'h00;
      flag_q      <= 1'b0;
      stat_q      <= '0;
      mask_q      <= '0;
      ready_q     <= 1'b0;
      err_q       <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      irq_q       <= 1'b0;
      maddr_q     <= slink_pkg::ADDR_RESET;
      mrd_q       <= 1'b0;
      wd_q        <= 1'b0;
      wdc_q       <= '0;
    end else begin
      vs_q        <= vs_d;
      option_q    <= option_d;
      index_q     <= index_d;
      last_q      <= last_d;
      txdata_q    <= txdata_d;
      rxdata_q    <= rxdata_d;
      buf_base_q  <= buf_base_d;
      buf_index_q <= buf_index_d;
      bptr_q      <= bptr_d;
      sum_q       <= sum_d;
      flag_q      <= flag_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      ready_q     <= ready_d;
      err_q       <= err_d;
      rdata_q     <= rdata_d;
      irq_q       <= irq_d;
      maddr_q     <= maddr_d;
      mrd_q       <= mrd_d;
      wd_q        <= wd_d;
      wdc_q       <= wdc_d;
    end
  end

  // Memory array: no reset, contents are software's
  always_ff @(posedge pclk) begin
    if (buf_we) buf_mem[buf_waddr] <= buf_wdata;
  end

  assign prdata           = rdata_q;
  assign pready           = ready_q;
  assign pslverr          = err_q;
  assign mem_addr         = maddr_q;
  assign mem_rd_en        = mrd_q;
  assign watchdog_service = wd_q;
  assign irq              = irq_q;

  // ==========================================================
  // Checks
  a_wdog_first_service: assert property (@(posedge pclk) disable iff (!presetn)
    go_verify |=> (!wd_q && v_busy) [*8] ##17 (wd_q == $past(v_busy)))
    else $error("first watchdog service not at cycle 24");
  a_no_wdog_bytes: assert property (@(posedge pclk) disable iff (!presetn)
    (!v_busy && !$past(v_busy)) |-> !wd_q)
    else $error("watchdog serviced outside range check");
  a_sendout_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (vs_q == slink_pkg::V_DATA) |->
      (link_tx_req == (option_q == slink_pkg::OPTION_SENDOUT)))
    else $error("option byte chose wrong mode");
  a_sendout_buf_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (v_busy && option_q == slink_pkg::OPTION_SENDOUT) |-> !buf_we)
    else $error("buffer written in send-out mode");
  a_checksum_add: assert property (@(posedge pclk) disable iff (!presetn)
    (vs_q == slink_pkg::V_DATA) |=> sum_q == 8'($past(sum_q) + $past(mem_rd_data)))
    else $error("checksum not accumulated");
  a_mismatch_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (mismatch || (!flag_q && v_busy)) |=> !flag_q)
    else $error("flag survived a mismatch");
  a_index_past_end: assert property (@(posedge pclk) disable iff (!presetn)
    ev[slink_pkg::EV_VERIFY] |=> !v_busy && index_q == 16'($past(last_q) + 16'h0001))
    else $error("index not one past last address");
  a_read_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    (vs_q == slink_pkg::V_READ) |=> mem_rd_en && mem_addr == $past(index_q))
    else $error("memory read at wrong address");
endmodule // serial_byte_link_range_check
`default_nettype wire

// ===== design/slink_pkg.sv
// Constants shared by the serial byte link and the range checker.
// Assumes one clock, pclk, at 20 MHz; all counts are in pclk cycles.
`default_nettype none
package slink_pkg;
  // ==========================================================
  // Register offsets (APB byte addresses)
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_OPTION    = 8'h04;
  localparam logic [7:0] OFF_INDEX     = 8'h08;
  localparam logic [7:0] OFF_LAST      = 8'h0C;
  localparam logic [7:0] OFF_TXDATA    = 8'h10;
  localparam logic [7:0] OFF_RXDATA    = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;
  localparam logic [7:0] OFF_BUF_BASE  = 8'h24;
  localparam logic [7:0] OFF_BUF_INDEX = 8'h28;
  localparam logic [7:0] OFF_BUF_DATA  = 8'h2C;
  // ==========================================================
  // Field positions
  localparam int CTRL_VERIFY   = 0;
  localparam int CTRL_RX       = 1;
  localparam int CTRL_TX       = 2;
  localparam int ST_FLAG       = 0;
  localparam int ST_BUSY       = 1;
  localparam int ST_SUM_LSB    = 8;
  localparam int EV_RX_DONE    = 0;
  localparam int EV_TX_DONE    = 1;
  localparam int EV_VERIFY     = 2;
  localparam int EV_FRAME_ERR  = 3;
  localparam int NUM_EVENTS    = 4;
  // ==========================================================
  // Reset values and timing
  localparam logic [7:0]  OPTION_SENDOUT = 8'h00;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;
  localparam int BIT_CYCLES    = 256;
  localparam int WDOG_FIRST    = 24;
  localparam int WDOG_PERIOD   = 1024;
  localparam int BUF_DEPTH     = 256;
  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    L_IDLE    = 2'b00,
    L_RX_WAIT = 2'b01,
    L_RX_BITS = 2'b10,
    L_TX_BITS = 2'b11
  } link_state_t;
  typedef enum logic [2:0] {
    V_IDLE = 3'b000,
    V_READ = 3'b001,
    V_DATA = 3'b010,
    V_SEND = 3'b011,
    V_NEXT = 3'b100
  } verify_state_t;
endpackage
`default_nettype wire
